// ### design/drt_pkg.sv
/*
 * Constants for the refresh timer: register offset, field positions,
 * reset values and interval counts.
 * Assumes one CPU clock, where one clock state is one clock cycle.
 */
package drt_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REFRESH_CTL_OFFSET  = 8'h36;
  localparam int         REFRESH_ON_BIT      = 7;
  localparam int         EXTRA_WAIT_BIT      = 6;
  localparam int         INTERVAL_SEL_HI     = 1;
  localparam int         INTERVAL_SEL_LO     = 0;
  localparam logic [7:0] REFRESH_CTL_RESET   = 8'hC0;
  localparam logic [7:0] REFRESH_CTL_WR_MASK = 8'hC3;
  // ****************************************
  // Timing
  // ****************************************
  localparam logic [6:0] INTERVAL_00         = 7'h0A;
  localparam logic [6:0] INTERVAL_01         = 7'h14;
  localparam logic [6:0] INTERVAL_10         = 7'h28;
  localparam logic [6:0] INTERVAL_11         = 7'h50;
  localparam logic [1:0] CYCLE_SHORT         = 2'h2;
  localparam logic [1:0] CYCLE_LONG          = 2'h3;
  localparam int         ADDR_W              = 8;

  typedef enum logic [1:0] {
    DRT_IDLE  = 2'b00,
    DRT_TR1   = 2'b01,
    DRT_TR2   = 2'b11,
    DRT_WAIT  = 2'b10
  } drt_state_t;
endpackage

// ### design/drt_refresh_timer.sv
/*
 * Dynamic RAM refresh controller: refresh control register, refresh
 * timer, refresh bus cycle sequencer and refresh address counter.
 * Assumes the CPU core reports bus release, sleep, wait and the end
 * of each machine cycle as synchronous levels and pulses.
 */
// Operation
// R01 - refresh_on bit 7 gates insertion, resets 1
// R02 - bit 6 selects two or three clocks
// R03 - bits 1:0 select 10/20/40/80 interval
// R04 - after reset: every 10, 3 long
// R05 - no insertion in reset, release, sleep, wait
// R06 - timer runs on through bus release
// R07 - sleep request latched, inserted after first cycle
// R08 - later refreshes follow timer only
// R09 - address steps once per performed cycle
// R10 - timer free-runs, request cleared when served
`timescale 1ns/100ps
module drt_refresh_timer (
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic [7:0]                    reg_addr_i,
  input  wire logic [7:0]                    reg_wdata_i,
  output logic      [7:0]                    reg_rdata_o,
  input  wire logic                          bus_request_in_i,
  input  wire logic                          sleep_i,
  input  wire logic                          wait_i,
  input  wire logic                          mcycle_end_i,
  output logic                               refresh_cycle_o,
  output logic                               refresh_wait_state_o,
  output logic [drt_pkg::ADDR_W-1:0]         refresh_addr_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]                  ctl;
    logic [6:0]                  cnt;
    logic                        req;
    logic                        slept;
    logic                        post_sleep;
    drt_pkg::drt_state_t         st;
    logic                        long_cyc;
    logic [drt_pkg::ADDR_W-1:0]  addr;
    logic [7:0]                  rdata;
  } drt_regs_t;

  drt_regs_t s_q;
  drt_regs_t s_d;
  logic [6:0] interval;
  logic       tick;
  logic       blocked;
  logic       start;

  always_comb begin
    case (s_q.ctl[drt_pkg::INTERVAL_SEL_HI:drt_pkg::INTERVAL_SEL_LO]) // [R03]
      2'b00:   interval = drt_pkg::INTERVAL_00;
      2'b01:   interval = drt_pkg::INTERVAL_01;
      2'b10:   interval = drt_pkg::INTERVAL_10;
      default: interval = drt_pkg::INTERVAL_11;
    endcase
  end

  assign tick    = (s_q.cnt >= interval - 7'd1); // [R10]
  assign blocked = bus_request_in_i | sleep_i | wait_i; // [R05]
  // After sleep the held request waits for the first machine cycle end
  assign start   = s_q.ctl[drt_pkg::REFRESH_ON_BIT] & s_q.req & ~blocked & // [R01]
                   (s_q.st == drt_pkg::DRT_IDLE) & ~s_q.slept & (~s_q.post_sleep | mcycle_end_i); // [R07]

  always_comb begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    // ****************************************
    // Register access
    // ****************************************
    if (reg_wr_i && reg_addr_i == drt_pkg::REFRESH_CTL_OFFSET) begin
      s_d.ctl = reg_wdata_i & drt_pkg::REFRESH_CTL_WR_MASK;
    end
    if (reg_rd_i && reg_addr_i == drt_pkg::REFRESH_CTL_OFFSET) begin
      s_d.rdata = s_q.ctl;
    end
    // ****************************************
    // Timer, free running through release and sleep
    // ****************************************
    s_d.cnt = tick ? 7'd0 : s_q.cnt + 7'd1; // [R06] [R08]
    if (start) begin
      s_d.req = 1'b0; // [R10]
    end
    if (tick) begin
      s_d.req = 1'b1; // [R07] newer request replaces held one
    end
    s_d.slept = sleep_i;
    if (s_q.slept && !sleep_i) begin
      s_d.post_sleep = 1'b1;
    end
    if (start || mcycle_end_i || !s_q.req) begin
      s_d.post_sleep = (s_q.slept && !sleep_i) ? 1'b1 : 1'b0;
    end
    // ****************************************
    // Refresh cycle sequencer
    // ****************************************
    case (s_q.st)
      drt_pkg::DRT_IDLE: begin
        if (start) begin
          s_d.st       = drt_pkg::DRT_TR1;
          // Length fixed at start, a write mid-cycle waits for the next one
          s_d.long_cyc = s_q.ctl[drt_pkg::EXTRA_WAIT_BIT]; // [R02]
        end
      end
      drt_pkg::DRT_TR1: s_d.st = drt_pkg::DRT_TR2;
      drt_pkg::DRT_TR2: begin
        if (s_q.long_cyc) begin // [R02]
          s_d.st = drt_pkg::DRT_WAIT;
        end else begin
          s_d.st   = drt_pkg::DRT_IDLE;
          s_d.addr = s_q.addr + 1'b1; // [R09]
        end
      end
      drt_pkg::DRT_WAIT: begin
        s_d.st   = drt_pkg::DRT_IDLE;
        s_d.addr = s_q.addr + 1'b1; // [R09]
      end
      default: s_d.st = drt_pkg::DRT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q            <= '0; // [R05]
      s_q.ctl        <= drt_pkg::REFRESH_CTL_RESET; // [R01] [R02] [R03] [R04]
      s_q.st         <= drt_pkg::DRT_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o          = s_q.rdata;
  assign refresh_cycle_o      = (s_q.st != drt_pkg::DRT_IDLE);
  assign refresh_wait_state_o = (s_q.st == drt_pkg::DRT_WAIT); // [R02]
  assign refresh_addr_o       = s_q.addr;

  // ****************************************
  // Checks
  // ****************************************
  property p_reset_values;
    @(posedge sys_clk_i) $fell(reset_i) |-> s_q.ctl == 8'hC0;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad control reset value"); // [R01]

  property p_disabled;
    @(posedge sys_clk_i) disable iff (reset_i)
      (!s_q.ctl[7] && s_q.st == drt_pkg::DRT_IDLE) |=> s_q.st == drt_pkg::DRT_IDLE;
  endproperty
  a_disabled: assert property (p_disabled) else $error("refresh while disabled"); // [R01]

  property p_long_cycle;
    @(posedge sys_clk_i) disable iff (reset_i)
      ($rose(refresh_cycle_o) && $past(s_q.ctl[drt_pkg::EXTRA_WAIT_BIT])) |-> refresh_cycle_o [*3] ##1 !refresh_cycle_o;
  endproperty
  a_long_cycle: assert property (p_long_cycle) else $error("long cycle not three clocks"); // [R02]

  property p_short_cycle;
    @(posedge sys_clk_i) disable iff (reset_i)
      ($rose(refresh_cycle_o) && !$past(s_q.ctl[drt_pkg::EXTRA_WAIT_BIT])) |-> refresh_cycle_o [*2] ##1 !refresh_cycle_o;
  endproperty
  a_short_cycle: assert property (p_short_cycle) else $error("short cycle not two clocks"); // [R02]

  property p_blocked;
    @(posedge sys_clk_i) disable iff (reset_i)
      blocked |=> !$rose(refresh_cycle_o);
  endproperty
  a_blocked: assert property (p_blocked) else $error("refresh began while blocked"); // [R05]

  property p_addr_step;
    @(posedge sys_clk_i) disable iff (reset_i)
      $fell(refresh_cycle_o) |-> refresh_addr_o == $past(refresh_addr_o) + 1'b1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not stepped by one"); // [R09]

  property p_addr_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
      (s_q.st == drt_pkg::DRT_IDLE) |=> $stable(refresh_addr_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved without refresh"); // [R09]

  property p_timer_period;
    @(posedge sys_clk_i) disable iff (reset_i)
      (s_q.cnt == 7'h00 && interval == drt_pkg::INTERVAL_00) ##1 (interval == drt_pkg::INTERVAL_00) [*8] ##1
      (interval == drt_pkg::INTERVAL_00) |-> tick;
  endproperty
  a_timer_period: assert property (p_timer_period) else $error("interval of ten not kept"); // [R04]

  property p_request;
    @(posedge sys_clk_i) disable iff (reset_i)
      tick |=> s_q.req;
  endproperty
  a_request: assert property (p_request) else $error("request not raised"); // [R10]

  property p_req_served;
    @(posedge sys_clk_i) disable iff (reset_i)
      $rose(refresh_cycle_o) |-> s_q.req == $past(tick);
  endproperty
  a_req_served: assert property (p_req_served) else $error("request not cleared when served"); // [R10]

  property p_sleep_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
      (s_q.slept || (s_q.post_sleep && !mcycle_end_i)) |=> !$rose(refresh_cycle_o);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("held refresh before machine cycle end"); // [R07]

  property p_timer_runs;
    @(posedge sys_clk_i) disable iff (reset_i)
      (bus_request_in_i && !tick) |=> s_q.cnt == $past(s_q.cnt) + 7'h01;
  endproperty
  a_timer_runs: assert property (p_timer_runs) else $error("timer stopped in bus release"); // [R06]

  property p_read_back;
    @(posedge sys_clk_i) disable iff (reset_i)
      (reg_rd_i && reg_addr_i == drt_pkg::REFRESH_CTL_OFFSET) |=> reg_rdata_o == $past(s_q.ctl);
  endproperty
  a_read_back: assert property (p_read_back) else $error("control read back wrong"); // [R01]

endmodule

// ### bench/drt_dram_model.sv
/* Dynamic RAM on the processor bus, seen from the refresh side.
   Assumes registered refresh outputs on sys_clk_i. */
`timescale 1ns/100ps
module drt_dram_model (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        refresh_cycle_i,
  input  wire logic [7:0]  refresh_addr_i,
  output logic      [15:0] refresh_count_o,
  output logic      [7:0]  last_row_o
);
  logic prev_q;
  // Counts each refresh bus cycle and the row it used
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_q          <= 1'b0;
      refresh_count_o <= 16'h0000;
      last_row_o      <= 8'h00;
    end else begin
      prev_q <= refresh_cycle_i;
      if (refresh_cycle_i && !prev_q) begin
        refresh_count_o <= refresh_count_o + 16'h0001;
        last_row_o      <= refresh_addr_i;
      end
    end
  end
endmodule

// ### bench/testbench.sv
/* Testbench for the refresh timer.
   Assumes the design and the dram model compiled first. */
`timescale 1ns/100ps
module testbench;
  logic        clk, rst, wr, rd, bus, slp, wt, mce, rc, rws;
  logic [7:0]  addr, wd, rdat, ra, row, a;
  logic [15:0] cnt, c0;
  int          failures, n_compared, cyc, n, l;

  drt_refresh_timer i_dut (
    .sys_clk_i            (clk),
    .reset_i              (rst),
    .reg_wr_i             (wr),
    .reg_rd_i             (rd),
    .reg_addr_i           (addr),
    .reg_wdata_i          (wd),
    .reg_rdata_o          (rdat),
    .bus_request_in_i     (bus),
    .sleep_i              (slp),
    .wait_i               (wt),
    .mcycle_end_i         (mce),
    .refresh_cycle_o      (rc),
    .refresh_wait_state_o (rws),
    .refresh_addr_o       (ra)
  );

  drt_dram_model i_ram (
    .sys_clk_i       (clk),
    .reset_i         (rst),
    .refresh_cycle_i (rc),
    .refresh_addr_i  (ra),
    .refresh_count_o (cnt),
    .last_row_o      (row)
  );

  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk);
    wr   = 1'b1;
    addr = ad;
    wd   = d;
    @(negedge clk);
    wr   = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
    @(negedge clk);
    rd   = 1'b1;
    addr = ad;
    @(negedge clk);
    rd   = 1'b0;
    chk(rdat === e, "read data");
  endtask

  task automatic next_start(output int c);
    c = 0;
    while (rc !== 1'b0 && c < 400) begin
      @(negedge clk);
      c++;
    end
    while (rc !== 1'b1 && c < 400) begin
      @(negedge clk);
      c++;
    end
  endtask

  // Cycle length, wait state and spacing of refresh cycles
  task automatic period(input int per, input int len);
    next_start(n);
    next_start(n);
    l = 0;
    while (rc === 1'b1 && l < 9) begin
      chk(rws === (l == 2), "wait state");
      @(negedge clk);
      l++;
    end
    chk(l == len, "cycle length");
    next_start(n);
    chk(n + l == per, "interval");
    $display("period %0d len %0d done", per, len);
  endtask

  // Refresh held off by bus release, wait or disable
  task automatic hold(input int k);
    next_start(n);
    repeat (4) @(negedge clk);
    a  = ra;
    c0 = cnt;
    if (k == 2) begin
      wr_reg(8'h36, 8'h40);
    end else begin
      bus = (k == 0);
      wt  = (k == 1);
    end
    repeat (60) begin
      @(negedge clk);
      chk(rc === 1'b0 && ra === a, "held refresh");
    end
    bus = 1'b0;
    wt  = 1'b0;
    if (k == 2) begin
      wr_reg(8'h36, 8'hC0);
    end
    next_start(n);
    chk(n <= 12, "refresh after hold");
    repeat (4) @(negedge clk);
    chk(ra === a + 8'h01 && row === a && cnt === c0 + 16'h0001, "address step");
    $display("hold %0d done", k);
  endtask

  // Request latched in sleep, served after first machine cycle
  task automatic sleep_test();
    wr_reg(8'h36, 8'h83);
    next_start(n);
    repeat (3) @(negedge clk);
    a   = ra;
    slp = 1'b1;
    repeat (85) begin
      @(negedge clk);
      chk(rc === 1'b0, "sleep refresh");
    end
    slp = 1'b0;
    repeat (4) begin
      @(negedge clk);
      chk(rc === 1'b0, "early refresh");
    end
    mce = 1'b1;
    @(negedge clk);
    mce = 1'b0;
    chk(rc === 1'b1 && ra === a, "latched refresh");
    period(80, 2);
    $display("sleep done");
  endtask

  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("ERROR %0t timeout", $time);
      print_verdict();
    end
  end

  initial begin
    {rst, wr, rd, bus, slp, wt, mce, addr, wd} = {1'b1, 22'h00_0000};
    repeat (16) @(negedge clk);
    rst = 1'b0;
    period(10, 3);
    rd_chk(8'h36, 8'hC0);
    rd_chk(8'h35, 8'h00);
    wr_reg(8'h36, 8'hFF);
    rd_chk(8'h36, 8'hC3);
    for (int s = 0; s < 4; s++) begin
      wr_reg(8'h36, {1'b1, s[0], 4'h0, s[1:0]});
      period(10 << s, 2 + s[0]);
    end
    wr_reg(8'h36, 8'hC0);
    for (int k = 0; k < 3; k++) begin
      hold(k);
    end
    sleep_test();
    print_verdict();
  end
endmodule
